// file: design/request_decoder_pkg.sv
// Purpose: shared constants, types and field decoders for the serial request decoder
// Assumes: request streams arrive one bit per clock, bit 0 first
// Notes:   field helpers take the frame array indexed by bit position
package request_decoder_pkg;

	// request type codes, bits 1 to 3, first bit most significant
	typedef enum logic [2:0] {
		CODE_IMMEDIATE  = 3'h0,
		CODE_ISOCHRONOUS = 3'h1,
		CODE_PRIORITY   = 3'h2,
		CODE_FAIR       = 3'h3,
		CODE_READ       = 3'h4,
		CODE_WRITE      = 3'h5,
		CODE_ACCEL      = 3'h6,
		CODE_RESERVED   = 3'h7
	} req_code_type;

	// serial shifter states
	typedef enum logic [0:0] {
		SHIFT_IDLE = 1'b0,
		SHIFT_BITS = 1'b1
	} shift_state_type;

	// control line codes while the device owns the lines
	localparam logic [1:0] CTL_IDLE    = 2'h0;
	localparam logic [1:0] CTL_STATUS  = 2'h1;
	localparam logic [1:0] CTL_RECEIVE = 2'h2;
	localparam logic [1:0] CTL_GRANT   = 2'h3;

	// index of the last bit of each stream
	localparam logic [4:0] LAST_TYPE_BIT  = 5'h03;
	localparam logic [4:0] LAST_ACCEL     = 5'h05;
	localparam logic [4:0] LAST_BUS_SHORT = 5'h06;
	localparam logic [4:0] LAST_BUS_LONG  = 5'h07;
	localparam logic [4:0] LAST_READ      = 5'h08;
	localparam logic [4:0] LAST_WRITE     = 5'h10;

	// field positions
	localparam int ADDR_POS  = 4;
	localparam int DATA_POS  = 8;
	localparam int SPEED_POS = 4;
	localparam int ACCEL_POS = 4;

	// valid speed codes
	localparam logic [2:0] SPEED_BASE   = 3'h0;
	localparam logic [2:0] SPEED_DOUBLE = 3'h2;
	localparam logic [2:0] SPEED_QUAD   = 3'h4;

	// values after reset
	localparam logic       ACCEL_ON_RESET = 1'b1;
	localparam logic [4:0] INDEX_RESET    = 5'h00;

	// type code, bits 1..3
	function automatic req_code_type get_code(input logic [16:0] b);
		get_code = req_code_type'({b[1], b[2], b[3]});
	endfunction

	// four bit address, bits 4..7
	function automatic logic [3:0] get_addr(input logic [16:0] b);
		get_addr = {b[ADDR_POS], b[ADDR_POS+1], b[ADDR_POS+2], b[ADDR_POS+3]};
	endfunction

	// eight bit write data, bits 8..15
	function automatic logic [7:0] get_data(input logic [16:0] b);
		get_data = {b[DATA_POS], b[DATA_POS+1], b[DATA_POS+2], b[DATA_POS+3],
			b[DATA_POS+4], b[DATA_POS+5], b[DATA_POS+6], b[DATA_POS+7]};
	endfunction

	// speed field, bits 4..6
	function automatic logic [2:0] get_speed(input logic [16:0] b);
		get_speed = {b[SPEED_POS], b[SPEED_POS+1], b[SPEED_POS+2]};
	endfunction

	// true for the four bus request codes
	function automatic logic is_bus(input req_code_type c);
		is_bus = (c == CODE_IMMEDIATE) || (c == CODE_ISOCHRONOUS) ||
			(c == CODE_PRIORITY) || (c == CODE_FAIR);
	endfunction

	// true for a speed code the bus can send
	function automatic logic speed_ok(input logic [2:0] s);
		speed_ok = (s == SPEED_BASE) || (s == SPEED_DOUBLE) || (s == SPEED_QUAD);
	endfunction

endpackage

// file: design/request_frame_if.sv
// Purpose: carries a finished request frame from the shifter to the decoder
// Assumes: single clock domain
// Notes:   done is a one-cycle pulse, bits hold until the next frame starts
`timescale 1ns/1ns
`default_nettype none
interface request_frame_if;
	logic                               busy;  // a stream is being shifted in
	logic                               done;  // last bit taken, pulse
	logic                               good;  // stop bit and type valid
	request_decoder_pkg::req_code_type  code;  // type field of the frame
	logic [16:0]                        bits;  // frame, index is bit position

	modport source (output busy, output done, output good, output code, output bits);
	modport sink   (input busy, input done, input good, input code, input bits);
endinterface
`default_nettype wire

// file: design/request_shifter.sv
// Purpose: synchronises the request pin and shifts request streams in
// Assumes: pin idles low, one bit per clock
// Notes:   a reserved type ends the frame after the type bits, marked bad
`timescale 1ns/1ns
`default_nettype none
module request_shifter (
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic        link_request_line,
	request_frame_if.source  frame
);
	// whole state of the shifter
	typedef struct packed {
		logic                                 s1;     // first sync stage
		logic                                 s2;     // second sync stage
		logic                                 s3;     // third sync stage
		logic                                 line;   // pin level after sync
		request_decoder_pkg::shift_state_type state;  // idle or shifting
		logic [4:0]                           index;  // next bit position
		logic [16:0]                          bits;   // frame so far
		logic                                 done;   // frame end pulse
		logic                                 good;   // frame well formed
	} shifter_type;

	shifter_type                        st;         // registered state
	shifter_type                        next_st;    // next state
	request_decoder_pkg::req_code_type  code_now;   // type incl. current bit
	logic                               last_bit;   // current bit ends frame

	// next state: sync, shift
	always_comb begin
		next_st = st;
		next_st.s1 = link_request_line;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		next_st.done = 1'b0;
		next_st.good = 1'b0;
		last_bit = 1'b0;
		// a stream bit stands for one clock only, so the third stage is taken
		// as it is: waiting for two stages to agree would swallow lone bits
		next_st.line = st.s3;
		// type field, third type bit may be on the line now
		if (st.index == request_decoder_pkg::LAST_TYPE_BIT) begin
			code_now = request_decoder_pkg::req_code_type'({st.bits[1], st.bits[2], st.line});
		end else begin
			code_now = request_decoder_pkg::get_code(st.bits);
		end
		case (st.state)
			request_decoder_pkg::SHIFT_IDLE: begin
				// start bit of 1 opens a frame
				if (st.line) begin
					next_st.state = request_decoder_pkg::SHIFT_BITS;
					next_st.bits = 17'h0_0001;
					next_st.index = 5'h01;
				end
			end
			request_decoder_pkg::SHIFT_BITS: begin
				next_st.bits[st.index] = st.line;
				// frame length by type
				if (st.index >= request_decoder_pkg::LAST_TYPE_BIT) begin
					case (code_now)
						request_decoder_pkg::CODE_READ:
							last_bit = (st.index == request_decoder_pkg::LAST_READ);
						request_decoder_pkg::CODE_WRITE:
							last_bit = (st.index == request_decoder_pkg::LAST_WRITE);
						request_decoder_pkg::CODE_ACCEL:
							last_bit = (st.index == request_decoder_pkg::LAST_ACCEL);
						request_decoder_pkg::CODE_RESERVED:
							last_bit = 1'b1;
						default: begin
							// bus request, stop may be left off after a 0 in bit 6
							last_bit = (st.index == request_decoder_pkg::LAST_BUS_LONG) ||
								((st.index == request_decoder_pkg::LAST_BUS_SHORT) && !st.line);
						end
					endcase
				end
				if (last_bit) begin
					// stop bit must be 0
					next_st.state = request_decoder_pkg::SHIFT_IDLE;
					next_st.index = request_decoder_pkg::INDEX_RESET;
					next_st.done = 1'b1;
					next_st.good = (code_now != request_decoder_pkg::CODE_RESERVED) && !st.line;
				end else begin
					next_st.index = st.index + 5'h01;
				end
			end
			default: begin
				next_st.state = request_decoder_pkg::SHIFT_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge clock) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// frame hand-off
	assign frame.busy = (st.state == request_decoder_pkg::SHIFT_BITS);
	assign frame.done = st.done;
	assign frame.good = st.good;
	assign frame.code = request_decoder_pkg::get_code(st.bits);
	assign frame.bits = st.bits;

	// a read stream ends on its ninth bit
	read_length_a: assert property (@(posedge clock) disable iff (srst)
		st.state == request_decoder_pkg::SHIFT_BITS && st.index == request_decoder_pkg::LAST_READ
		&& request_decoder_pkg::get_code(st.bits) == request_decoder_pkg::CODE_READ
		|=> st.done && st.state == request_decoder_pkg::SHIFT_IDLE)
		else $error("read stream did not end on bit 8");

	// a write stream runs to bit 16
	write_length_a: assert property (@(posedge clock) disable iff (srst)
		st.state == request_decoder_pkg::SHIFT_BITS && st.index == 5'h08
		&& request_decoder_pkg::get_code(st.bits) == request_decoder_pkg::CODE_WRITE
		|=> !st.done ##7 st.state == request_decoder_pkg::SHIFT_BITS ##1 st.done)
		else $error("write stream length wrong");

	// a start bit opens a frame
	start_bit_a: assert property (@(posedge clock) disable iff (srst)
		st.state == request_decoder_pkg::SHIFT_IDLE && st.line
		|=> st.state == request_decoder_pkg::SHIFT_BITS && st.index == 5'h01)
		else $error("start bit not taken");
endmodule
`default_nettype wire

// file: design/link_request_decoder.sv
// Purpose: decodes serial requests from the link controller and keeps request state
// Assumes: control line code and bus events come from logic on the same clock
// Notes:   register storage lives outside; this block strobes writes and holds reads
//
// Notes on behaviour
// - bad speed: accept, then send null packet
// - read stream: 9 bits, type 100
// - write stream: 17 bits, type 101
// - accel stream: 6 bits, control in bit 4
// - receive code drops pending fair/priority request
// - receive during fair/priority stream drops it
// - isochronous request held until bus won
// - immediate request granted when reception ends
// - new bus request ignored while one pending
// - bus reset clears pending bus requests
// - write lands right after its last bit
// - read held and retried until delivered
// - register requests taken any time
// - further reads ignored until delivery
// - bus reset keeps a pending read
// - enhancements only while enable bit set
// - reset or isochronous request re-enables acceleration
// - start 1, stop 0, first bit first
// - type codes 000 to 111
// - speed field bits 4-6, three valid codes
// - control line codes idle, status, receive, grant
`timescale 1ns/1ns
`default_nettype none
module link_request_decoder (
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic        link_request_line,
	input  wire logic [1:0]  interface_control_lines_state,
	input  wire logic        bus_reset,
	input  wire logic        bus_won,
	input  wire logic        arbitration_acceleration_enable,
	input  wire logic        read_delivered,
	output logic             request_pending,
	output logic [2:0]       request_kind,
	output logic [2:0]       request_speed,
	output logic             send_null_packet,
	output logic             grant_after_receive,
	output logic             register_write_strobe,
	output logic [3:0]       register_write_address,
	output logic [7:0]       register_write_data,
	output logic             read_pending,
	output logic [3:0]       read_address,
	output logic             enhancements_active
);
	// whole state of the decoder
	typedef struct packed {
		logic                               bus_pending;   // bus request held
		request_decoder_pkg::req_code_type  kind;          // held request type
		logic [2:0]                         speed;         // held speed code
		logic                               speed_bad;     // speed not sendable
		logic                               rx_seen;       // receive during stream
		logic                               read_pending;  // read awaiting delivery
		logic [3:0]                         read_addr;     // register to return
		logic                               wr_strobe;     // write pulse
		logic [3:0]                         wr_addr;       // write address
		logic [7:0]                         wr_data;       // write data
		logic                               accel_on;      // acceleration allowed
		logic                               accel_applied; // gated by enable bit
	} decoder_type;

	request_frame_if  frame ();       // shifter to decoder
	decoder_type      st;             // registered state
	decoder_type      next_st;        // next state
	logic             receiving;      // device shows receive code
	logic             fair_or_pri;    // held request is fair or priority
	logic             frame_fair_pri; // finished frame is fair or priority
	logic             take_bus;       // finished frame is a bus request

	// serial input stage
	request_shifter u_shifter (
		.clock             (clock),
		.srst              (srst),
		.link_request_line (link_request_line),
		.frame             (frame)
	);

	// line state and frame class
	assign receiving = (interface_control_lines_state == request_decoder_pkg::CTL_RECEIVE);
	assign fair_or_pri = (st.kind == request_decoder_pkg::CODE_FAIR) ||
		(st.kind == request_decoder_pkg::CODE_PRIORITY);
	assign frame_fair_pri = (frame.code == request_decoder_pkg::CODE_FAIR) ||
		(frame.code == request_decoder_pkg::CODE_PRIORITY);
	assign take_bus = frame.done && frame.good && request_decoder_pkg::is_bus(frame.code);

	// next state
	always_comb begin
		next_st = st;
		next_st.wr_strobe = 1'b0;

		// remember a receive seen while a stream is arriving
		if (!frame.busy) begin
			next_st.rx_seen = 1'b0;
		end else if (receiving) begin
			next_st.rx_seen = 1'b1;
		end

		// clearing of a held bus request
		if (st.bus_pending) begin
			if (bus_reset) begin
				next_st.bus_pending = 1'b0;
			end else if (bus_won) begin
				next_st.bus_pending = 1'b0;
			end else if (receiving && fair_or_pri) begin
				next_st.bus_pending = 1'b0;
			end
		end else if (take_bus && !bus_reset) begin
			// new request only when none is held
			if (!(frame_fair_pri && (st.rx_seen || receiving))) begin
				next_st.bus_pending = 1'b1;
				next_st.kind = frame.code;
				next_st.speed = request_decoder_pkg::get_speed(frame.bits);
				next_st.speed_bad = !request_decoder_pkg::speed_ok(
					request_decoder_pkg::get_speed(frame.bits));
			end
		end

		// register requests, accepted regardless of bus state
		if (frame.done && frame.good) begin
			case (frame.code)
				request_decoder_pkg::CODE_WRITE: begin
					next_st.wr_strobe = 1'b1;
					next_st.wr_addr = request_decoder_pkg::get_addr(frame.bits);
					next_st.wr_data = request_decoder_pkg::get_data(frame.bits);
				end
				request_decoder_pkg::CODE_READ: begin
					// a second read is ignored while the first is pending
					if (!st.read_pending) begin
						next_st.read_pending = 1'b1;
						next_st.read_addr = request_decoder_pkg::get_addr(frame.bits);
					end
				end
				request_decoder_pkg::CODE_ACCEL: begin
					next_st.accel_on = frame.bits[request_decoder_pkg::ACCEL_POS];
				end
				default: begin
				end
			endcase
		end

		// read cleared only by full delivery, not by bus reset
		if (st.read_pending && read_delivered) begin
			next_st.read_pending = 1'b0;
		end

		// reset or accepted isochronous request restores acceleration
		if (bus_reset || (take_bus && !st.bus_pending &&
			frame.code == request_decoder_pkg::CODE_ISOCHRONOUS)) begin
			if (arbitration_acceleration_enable) begin
				next_st.accel_on = 1'b1;
			end
		end

		// enhancements gated by the enable bit
		next_st.accel_applied = arbitration_acceleration_enable && next_st.accel_on;
	end

	// state register
	always_ff @(posedge clock) begin
		if (srst) begin
			st <= '0;
			st.accel_on <= request_decoder_pkg::ACCEL_ON_RESET;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from state
	assign request_pending = st.bus_pending;
	assign request_kind = st.kind;
	assign request_speed = st.speed;
	assign send_null_packet = st.bus_pending && st.speed_bad;
	assign grant_after_receive = st.bus_pending &&
		(st.kind == request_decoder_pkg::CODE_IMMEDIATE);
	assign register_write_strobe = st.wr_strobe;
	assign register_write_address = st.wr_addr;
	assign register_write_data = st.wr_data;
	assign read_pending = st.read_pending;
	assign read_address = st.read_addr;
	assign enhancements_active = st.accel_applied;

	// write strobe follows the last bit of a write
	write_lands_a: assert property (@(posedge clock) disable iff (srst)
		frame.done && frame.good && frame.code == request_decoder_pkg::CODE_WRITE
		|=> register_write_strobe &&
		register_write_address == request_decoder_pkg::get_addr($past(frame.bits)) ##1
		!register_write_strobe)
		else $error("register write not strobed after its last bit");

	// isochronous request stays until won or reset
	iso_hold_a: assert property (@(posedge clock) disable iff (srst)
		request_pending && request_kind == request_decoder_pkg::CODE_ISOCHRONOUS
		&& !bus_won && !bus_reset |=> request_pending)
		else $error("isochronous request dropped before winning");

	// receive code clears fair and priority
	rx_clears_a: assert property (@(posedge clock) disable iff (srst)
		request_pending && receiving && !bus_reset && !bus_won &&
		(request_kind == request_decoder_pkg::CODE_FAIR ||
		request_kind == request_decoder_pkg::CODE_PRIORITY)
		|=> !request_pending)
		else $error("fair or priority request survived receive");

	// bus reset leaves no bus request pending
	reset_clears_a: assert property (@(posedge clock) disable iff (srst)
		bus_reset |=> !request_pending)
		else $error("bus request pending after bus reset");

	// bus reset does not drop a read
	read_kept_a: assert property (@(posedge clock) disable iff (srst)
		read_pending && bus_reset && !read_delivered |=> read_pending)
		else $error("bus reset cleared pending read");

	// second read does not replace the first
	read_ignored_a: assert property (@(posedge clock) disable iff (srst)
		read_pending && !read_delivered && frame.done
		&& frame.code == request_decoder_pkg::CODE_READ
		|=> read_pending && $stable(read_address))
		else $error("read accepted while another pending");

	// held request unchanged by a newer one
	busy_ignore_a: assert property (@(posedge clock) disable iff (srst)
		request_pending && take_bus && !bus_won && !bus_reset && !receiving
		|=> request_pending && $stable(request_kind) && $stable(request_speed))
		else $error("new bus request replaced a pending one");

	// null packet flag tracks speed validity
	null_packet_a: assert property (@(posedge clock) disable iff (srst)
		request_pending |-> send_null_packet == !request_decoder_pkg::speed_ok(request_speed))
		else $error("null packet flag wrong for speed code");

	// enhancements off without the enable bit
	accel_gate_a: assert property (@(posedge clock) disable iff (srst)
		!arbitration_acceleration_enable |=> !enhancements_active)
		else $error("enhancements active without enable bit");

	// control request takes effect next cycle
	accel_ctl_a: assert property (@(posedge clock) disable iff (srst)
		frame.done && frame.good && frame.code == request_decoder_pkg::CODE_ACCEL
		&& arbitration_acceleration_enable && !bus_reset
		|=> enhancements_active == $past(frame.bits[request_decoder_pkg::ACCEL_POS]))
		else $error("acceleration control not applied");

	// bus reset restores acceleration when enabled
	accel_restore_a: assert property (@(posedge clock) disable iff (srst)
		bus_reset && arbitration_acceleration_enable |=> enhancements_active)
		else $error("acceleration not restored on bus reset");
endmodule
`default_nettype wire

// file: testbench/link_controller_model.sv
// Purpose: behavioural link controller that shifts request frames onto the pin
// Assumes: the bench starts one frame at a time and leaves idle clocks between frames
// Notes:   the pin returns low between frames
`timescale 1ns/1ns
`default_nettype none
module link_controller_model (
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic        start,
	input  wire logic [16:0] frame,
	input  wire logic [4:0]  count,
	output logic             line,
	output logic             busy
);
	logic [4:0] index;  // next bit position to send

	// one bit per clock, start bit first, idle low
	always_ff @(posedge clock) begin
		if (srst) begin
			busy <= 1'b0;
			line <= 1'b0;
			index <= 5'h00;
		end else if (!busy && start) begin
			busy <= 1'b1;
			line <= frame[0];
			index <= 5'h01;
		end else if (busy && index == count) begin
			busy <= 1'b0;
			line <= 1'b0;
		end else if (busy) begin
			line <= frame[index];
			index <= index + 5'h01;
		end
	end
endmodule
`default_nettype wire

// file: testbench/link_request_decoder_bench.sv
// Purpose: self-checking bench for the serial request decoder
// Assumes: the controller model shifts frames, the bench drives the device-side inputs
// Notes:   outputs are sampled 1 ns after the clock edge
`timescale 1ns/1ns
`default_nettype none
module link_request_decoder_bench;
	typedef struct packed {
		logic [2:0] code;   // bus request type
		logic [2:0] speed;  // speed field
		logic       bad;    // null packet expected
		logic       imm;    // grant after receive expected
	} row_type;
	logic        clock, srst, start, busy, line;  // clock, reset, model handshake
	logic [1:0]  ctl;                             // control line code
	logic        bus_reset, bus_won, enable;      // bus events, enable bit
	logic        delivered;                       // read delivered pulse
	logic [16:0] frame;                           // frame bits by position
	logic [4:0]  count;                           // frame length in bits
	logic        pend, nul, grant, strobe, rpend, enh;
	logic [2:0]  kind, speed;
	logic [3:0]  waddr, raddr;
	logic [7:0]  wdata;
	int          miscompares, check_count, strobes, cycles;
	// priority (cycle start) is won before the isochronous row
	row_type     rows [5] = '{'{3'h0, 3'h0, 1'b0, 1'b1}, '{3'h2, 3'h4, 1'b0, 1'b0},
		'{3'h1, 3'h2, 1'b0, 1'b0}, '{3'h3, 3'h3, 1'b1, 1'b0}, '{3'h2, 3'h1, 1'b1, 1'b0}};

	link_controller_model model_u (.clock(clock), .srst(srst), .start(start), .frame(frame),
		.count(count), .line(line), .busy(busy));
	link_request_decoder dut_u (.clock(clock), .srst(srst), .link_request_line(line),
		.interface_control_lines_state(ctl), .bus_reset(bus_reset), .bus_won(bus_won),
		.arbitration_acceleration_enable(enable), .read_delivered(delivered),
		.request_pending(pend), .request_kind(kind), .request_speed(speed),
		.send_null_packet(nul), .grant_after_receive(grant), .register_write_strobe(strobe),
		.register_write_address(waddr), .register_write_data(wdata), .read_pending(rpend),
		.read_address(raddr), .enhancements_active(enh));

	// clock at 20 ns period
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	// strobe counter and hang guard
	always @(posedge clock) begin
		if (strobe === 1'b1) strobes++;
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			tally_and_finish;
		end
	end

	// frame with start 1, type first bit first, payload, stop 0
	function automatic logic [16:0] mk(input logic [2:0] code, input logic [11:0] pl,
		input int n);
		logic [16:0] b;
		b = 17'h0_0001;
		b[1] = code[2];
		b[2] = code[1];
		b[3] = code[0];
		for (int i = 0; i < n; i++) b[4 + i] = pl[n - 1 - i];
		return b;
	endfunction

	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] seen);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// sends one frame, optional receive code rx clocks in, then idles
	task automatic send(input logic [2:0] code, input logic [11:0] pl, input int n,
		input int rx);
		@(posedge clock);
		frame <= mk(code, pl, n);
		count <= 5'(5 + n);
		start <= 1'b1;
		@(posedge clock);
		start <= 1'b0;
		repeat (rx) @(posedge clock);
		if (rx > 0) ctl <= 2'h2;
		@(posedge clock);
		ctl <= 2'h0;
		while (busy === 1'b1) @(posedge clock);
		repeat (10) @(posedge clock);
		#1;
	endtask

	// one-cycle event: 0 won, 1 bus reset, 2 delivered, 3 receive code
	task automatic pulse(input int k);
		@(posedge clock);
		if (k == 0) bus_won <= 1'b1;
		else if (k == 1) bus_reset <= 1'b1;
		else if (k == 2) delivered <= 1'b1;
		else ctl <= 2'h2;
		@(posedge clock);
		bus_won <= 1'b0;
		bus_reset <= 1'b0;
		delivered <= 1'b0;
		ctl <= 2'h0;
		repeat (3) @(posedge clock);
		#1;
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// main sequence
	initial begin
		{srst, start, bus_reset, bus_won, delivered, enable} = 6'h21;
		{ctl, frame, count} = '0;
		repeat (5) @(posedge clock);
		srst <= 1'b0;
		repeat (6) @(posedge clock);
		#1;
		check("pending_reset", 8'h00, 8'(pend));
		check("read_reset", 8'h00, 8'(rpend));
		foreach (rows[i]) begin
			send(rows[i].code, {9'h000, rows[i].speed}, 3, 0);
			check("pending", 8'h01, 8'(pend));
			check("kind", 8'(rows[i].code), 8'(kind));
			check("speed", 8'(rows[i].speed), 8'(speed));
			check("null", 8'(rows[i].bad), 8'(nul));
			check("grant", 8'(rows[i].imm), 8'(grant));
			pulse(0);
			check("won", 8'h00, 8'(pend));
		end
		send(3'h5, 12'ha5c, 12, 0);
		check("strobes", 8'h01, 8'(strobes));
		check("waddr", 8'h0a, 8'(waddr));
		check("wdata", 8'h5c, wdata);
		send(3'h4, 12'h003, 4, 0);
		check("rpend", 8'h01, 8'(rpend));
		check("raddr", 8'h03, 8'(raddr));
		send(3'h4, 12'h007, 4, 0);
		check("raddr_hold", 8'h03, 8'(raddr));
		pulse(1);
		check("read_keep", 8'h01, 8'(rpend));
		send(3'h0, 12'h000, 3, 0);
		check("bus_with_read", 8'h01, 8'(pend));
		send(3'h3, 12'h002, 3, 0);
		check("kind_hold", 8'h00, 8'(kind));
		pulse(2);
		check("read_done", 8'h00, 8'(rpend));
		pulse(1);
		check("reset_clear", 8'h00, 8'(pend));
		send(3'h3, 12'h002, 3, 0);
		pulse(3);
		check("rx_clear", 8'h00, 8'(pend));
		send(3'h1, 12'h000, 3, 0);
		pulse(3);
		check("iso_hold", 8'h01, 8'(pend));
		pulse(0);
		send(3'h3, 12'h002, 3, 6);
		check("rx_during", 8'h00, 8'(pend));
		send(3'h6, 12'h000, 1, 0);
		check("accel_off", 8'h00, 8'(enh));
		send(3'h6, 12'h001, 1, 0);
		check("accel_on", 8'h01, 8'(enh));
		send(3'h6, 12'h000, 1, 0);
		pulse(1);
		check("reset_on", 8'h01, 8'(enh));
		send(3'h6, 12'h000, 1, 0);
		send(3'h1, 12'h000, 3, 0);
		check("iso_on", 8'h01, 8'(enh));
		pulse(0);
		@(posedge clock);
		enable <= 1'b0;
		repeat (4) @(posedge clock);
		#1;
		check("enable_off", 8'h00, 8'(enh));
		tally_and_finish;
	end
endmodule
`default_nettype wire
